// file: sbr_pkg.sv
// Package of the status byte and service request block: bit positions, reset values,
// command codes, self-test constants and the self-test state type.
// Assumes a command decoder outside hands over one common command per cycle.
package sbr_pkg;

    localparam int SBR_LVL_W = 16;

    // Status byte bit positions.
    localparam int STB_OPER = 7;
    localparam int STB_MSS = 6;
    localparam int STB_ESB = 5;
    localparam int STB_MAV = 4;
    localparam int STB_QUES = 3;
    localparam int STB_ERRQ = 2;
    localparam int STB_LIST = 1;
    localparam int STB_UNUSED = 0;

    // Event status register bit positions.
    localparam int ESR_PON = 7;
    localparam int ESR_CME = 5;
    localparam int ESR_EXE = 4;
    localparam int ESR_DDE = 3;
    localparam int ESR_QYE = 2;
    localparam int ESR_OPC = 0;

    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] ESE_RESET = 8'h00;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] SRE_WRITABLE = 8'hbf;
    localparam logic [7:0] RESP_RESET = 8'h00;

    // Error classes reported by the parser: 1xx, 2xx, 3xx, 4xx.
    localparam logic [1:0] ERR_CLASS_CMD = 2'h0;
    localparam logic [1:0] ERR_CLASS_EXE = 2'h1;
    localparam logic [1:0] ERR_CLASS_DEV = 2'h2;
    localparam logic [1:0] ERR_CLASS_QRY = 2'h3;

    // Output level reset values.
    localparam logic [SBR_LVL_W-1:0] VOLT_ZERO = 16'h0000;
    localparam logic [SBR_LVL_W-1:0] CURR_MIN_DEFAULT = 16'h0001;

    // Self-test checksum and answers.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] TST_PASS = 8'h00;
    localparam logic [7:0] TST_FAIL = 8'h01;

    // Common command codes; any other code is an unrecognised command.
    typedef logic [4:0] sbr_cmd_t;
    localparam sbr_cmd_t CMD_CLS = 5'h00;
    localparam sbr_cmd_t CMD_ESE = 5'h01;
    localparam sbr_cmd_t CMD_ESE_Q = 5'h02;
    localparam sbr_cmd_t CMD_ESR_Q = 5'h03;
    localparam sbr_cmd_t CMD_OPC = 5'h04;
    localparam sbr_cmd_t CMD_RST = 5'h05;
    localparam sbr_cmd_t CMD_SRE = 5'h06;
    localparam sbr_cmd_t CMD_SRE_Q = 5'h07;
    localparam sbr_cmd_t CMD_STB_Q = 5'h08;
    localparam sbr_cmd_t CMD_TRG = 5'h09;
    localparam sbr_cmd_t CMD_TST_Q = 5'h0a;
    localparam sbr_cmd_t CMD_WAI = 5'h0b;
    localparam sbr_cmd_t CMD_INIT_IMM = 5'h0c;
    localparam sbr_cmd_t CMD_INIT_CONT = 5'h0d;
    localparam sbr_cmd_t CMD_ABORT = 5'h0e;
    localparam sbr_cmd_t CMD_TRIG_SRC = 5'h0f;
    localparam sbr_cmd_t CMD_OUTP = 5'h10;

    typedef enum logic [3:0]
    {
        TS_IDLE = 4'b0001,
        TS_READ = 4'b0010,
        TS_DRAIN = 4'b0100,
        TS_DONE = 4'b1000
    } sbr_tst_e;

endpackage

// file: sbr_nvm_if.sv
// Interface between the status block and its nonvolatile store model.
// Assumes a single clock shared by both modules.
`timescale 1ns/1ps
interface sbr_nvm_if #(parameter int AW = 6);
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data;
    modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
    modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// file: sbr_nvm.sv
// Byte-wide store checked by the self-test, with registered read data.
// Assumes the controller holds rd_addr and takes rd_data one cycle later.
`timescale 1ns/1ps
module sbr_nvm #(
    parameter int DEPTH = 64,
    parameter int AW = 6
)
(
    // Clock.
    input wire logic CLK,
    // Store access.
    sbr_nvm_if.mem nvm
);
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] rd_reg;

    always_ff @(posedge CLK)
    begin
        if (nvm.wr_en)
        begin
            mem_reg[nvm.wr_addr] <= nvm.wr_data;
        end
    end

    always_ff @(posedge CLK)
    begin
        rd_reg <= mem_reg[nvm.rd_addr];
    end

    assign nvm.rd_data = rd_reg;
endmodule

// file: sbr_status_top.sv
// Status byte, service request, event status, bus trigger and self-test logic.
// Assumes a parser outside decodes common commands and hands them over one per cycle.
`timescale 1ns/1ps
module sbr_status_top
    import sbr_pkg::*;
#(
    parameter int NVM_DEPTH = 64,
    parameter int NVM_AW = 6,
    parameter logic [15:0] CURR_MIN = CURR_MIN_DEFAULT
)
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Command hand-over.
    input wire logic CMD_VALID,
    input wire sbr_pkg::sbr_cmd_t CMD_CODE,
    input wire logic [7:0] CMD_ARG,
    output logic CMD_READY,
    input wire logic LISTEN_ADDRESSED,
    input wire logic GROUP_TRIGGER,
    // Query answers.
    output logic RESP_VALID,
    output logic [7:0] RESP_DATA,
    // Serial poll.
    input wire logic SERIAL_POLL,
    output logic POLL_VALID,
    output logic [7:0] POLL_DATA,
    output logic SERVICE_REQUEST,
    // Status sources.
    input wire logic OPER_SUMMARY,
    input wire logic QUES_SUMMARY,
    input wire logic MSG_AVAILABLE,
    input wire logic ERROR_QUEUE_NONEMPTY,
    input wire logic LIST_RUNNING,
    input wire logic OPS_BUSY,
    input wire logic ERR_VALID,
    input wire logic [1:0] ERR_CLASS,
    // Trigger levels and output programming.
    input wire logic [15:0] TRIG_VOLT,
    input wire logic [15:0] TRIG_CURR,
    output logic [15:0] OUT_VOLT,
    output logic [15:0] OUT_CURR,
    output logic OUT_ON,
    output logic WAIT_FOR_TRIGGER,
    // Store fill path.
    input wire logic NV_WR_EN,
    input wire logic [NVM_AW-1:0] NV_WR_ADDR,
    input wire logic [7:0] NV_WR_DATA
);
    import sbr_pkg::*;

    localparam logic [NVM_AW-1:0] NVM_LAST = NVM_AW'(NVM_DEPTH - 1);
    localparam int TST_MAX = NVM_DEPTH + 4;

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] sre_reg, ese_reg, esr_reg, esr_next, esr_set;
    logic rqs_reg, mss_prev_reg, opc_pend_reg;
    logic armed_reg, cont_reg, src_bus_reg;
    logic ready_reg;
    logic taken, known, mss, esb, trg_req, trg_fire;
    logic [7:0] stb;
    sbr_tst_e tst_reg, tst_next;
    logic [NVM_AW-1:0] addr_reg, vidx_reg;
    logic vld_reg, fail_reg;
    logic [7:0] crc_reg;
    sbr_nvm_if #(.AW(NVM_AW)) nvm_bus ();

    sbr_nvm #(.DEPTH(NVM_DEPTH), .AW(NVM_AW)) u_nvm
    (
        .CLK(CLK),
        .nvm(nvm_bus.mem)
    );

    assign nvm_bus.rd_addr = addr_reg;
    assign nvm_bus.wr_en = NV_WR_EN;
    assign nvm_bus.wr_addr = NV_WR_ADDR;
    assign nvm_bus.wr_data = NV_WR_DATA;

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode and status byte assembly.
    always_comb
    begin
        taken = CMD_VALID && ready_reg;
        unique case (CMD_CODE)
            CMD_CLS, CMD_ESE, CMD_ESE_Q, CMD_ESR_Q, CMD_OPC, CMD_RST, CMD_SRE,
            CMD_SRE_Q, CMD_STB_Q, CMD_TRG, CMD_TST_Q, CMD_WAI, CMD_INIT_IMM,
            CMD_INIT_CONT, CMD_ABORT, CMD_TRIG_SRC, CMD_OUTP: known = 1'b1;
            default: known = 1'b0;
        endcase
        esb = |(esr_reg & ese_reg);
        stb = 8'h00;
        stb[STB_OPER] = OPER_SUMMARY;
        stb[STB_ESB] = esb;
        stb[STB_MAV] = MSG_AVAILABLE;
        stb[STB_QUES] = QUES_SUMMARY;
        stb[STB_ERRQ] = ERROR_QUEUE_NONEMPTY;
        stb[STB_LIST] = LIST_RUNNING;
        stb[STB_UNUSED] = 1'b0;
        mss = |(stb & sre_reg);
        stb[STB_MSS] = mss;
        // Group execute trigger and the trigger command both need listener addressing.
        trg_req = LISTEN_ADDRESSED && ((taken && CMD_CODE == CMD_TRG) || GROUP_TRIGGER);
        trg_fire = trg_req && armed_reg && src_bus_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable masks.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            sre_reg <= SRE_RESET;
            ese_reg <= ESE_RESET;
        end
        else if (taken && CMD_CODE == CMD_SRE)
        begin
            sre_reg <= CMD_ARG & SRE_WRITABLE;
        end
        else if (taken && CMD_CODE == CMD_ESE)
        begin
            ese_reg <= CMD_ARG;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event status register; new events win over a clearing read.
    always_comb
    begin
        esr_set = 8'h00;
        if (ERR_VALID)
        begin
            unique case (ERR_CLASS)
                ERR_CLASS_CMD: esr_set[ESR_CME] = 1'b1;
                ERR_CLASS_EXE: esr_set[ESR_EXE] = 1'b1;
                ERR_CLASS_DEV: esr_set[ESR_DDE] = 1'b1;
                ERR_CLASS_QRY: esr_set[ESR_QYE] = 1'b1;
            endcase
        end
        if (taken && !known)
        begin
            esr_set[ESR_CME] = 1'b1;
        end
        if (taken && CMD_CODE == CMD_INIT_IMM && cont_reg)
        begin
            esr_set[ESR_EXE] = 1'b1;
        end
        if (opc_pend_reg && !OPS_BUSY)
        begin
            esr_set[ESR_OPC] = 1'b1;
        end
        esr_next = esr_reg;
        if (taken && (CMD_CODE == CMD_ESR_Q || CMD_CODE == CMD_CLS))
        begin
            esr_next = 8'h00;
        end
        esr_next = esr_next | esr_set;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            esr_reg <= ESR_RESET;
        end
        else
        begin
            esr_reg <= esr_next;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            opc_pend_reg <= 1'b0;
        end
        else if (taken && CMD_CODE == CMD_OPC)
        begin
            opc_pend_reg <= 1'b1;
        end
        else if (!OPS_BUSY || (taken && CMD_CODE == CMD_CLS))
        begin
            opc_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request for service and serial poll; a fresh reason wins over the poll clear.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            rqs_reg <= 1'b0;
            mss_prev_reg <= 1'b0;
            POLL_VALID <= 1'b0;
            POLL_DATA <= RESP_RESET;
        end
        else
        begin
            mss_prev_reg <= mss;
            rqs_reg <= (rqs_reg && !SERIAL_POLL) || (mss && !mss_prev_reg);
            POLL_VALID <= SERIAL_POLL;
            if (SERIAL_POLL)
            begin
                POLL_DATA <= {stb[7], rqs_reg, stb[5:0]};
            end
        end
    end

    assign SERVICE_REQUEST = rqs_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger arming and output programming.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            armed_reg <= 1'b0;
            cont_reg <= 1'b0;
            src_bus_reg <= 1'b0;
        end
        else if (taken && CMD_CODE == CMD_RST)
        begin
            armed_reg <= 1'b0;
            cont_reg <= 1'b0;
        end
        else if (trg_fire)
        begin
            armed_reg <= cont_reg;
        end
        else if (taken)
        begin
            unique case (CMD_CODE)
                CMD_INIT_IMM: armed_reg <= 1'b1;
                CMD_INIT_CONT:
                begin
                    cont_reg <= CMD_ARG[0];
                    armed_reg <= CMD_ARG[0] || armed_reg;
                end
                CMD_ABORT: armed_reg <= cont_reg;
                CMD_TRIG_SRC: src_bus_reg <= CMD_ARG[0];
                default: armed_reg <= armed_reg;
            endcase
        end
    end

    assign WAIT_FOR_TRIGGER = armed_reg;

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            OUT_VOLT <= VOLT_ZERO;
            OUT_CURR <= CURR_MIN;
            OUT_ON <= 1'b0;
        end
        else if (taken && CMD_CODE == CMD_RST)
        begin
            OUT_VOLT <= VOLT_ZERO;
            OUT_CURR <= CURR_MIN;
            OUT_ON <= 1'b0;
        end
        else if (trg_fire)
        begin
            OUT_VOLT <= TRIG_VOLT;
            OUT_CURR <= TRIG_CURR;
        end
        else if (taken && CMD_CODE == CMD_OUTP)
        begin
            OUT_ON <= CMD_ARG[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-test: checksum of all words but the last, compared with the last word.
    always_comb
    begin
        tst_next = tst_reg;
        unique case (tst_reg)
            TS_IDLE: if (taken && CMD_CODE == CMD_TST_Q) tst_next = TS_READ;
            TS_READ: if (addr_reg == NVM_LAST) tst_next = TS_DRAIN;
            TS_DRAIN: tst_next = TS_DONE;
            TS_DONE: tst_next = TS_IDLE;
            default: tst_next = TS_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            tst_reg <= TS_IDLE;
            ready_reg <= 1'b0;
            addr_reg <= '0;
            vld_reg <= 1'b0;
            vidx_reg <= '0;
        end
        else
        begin
            tst_reg <= tst_next;
            ready_reg <= (tst_next == TS_IDLE);
            vld_reg <= (tst_reg == TS_READ);
            vidx_reg <= addr_reg;
            addr_reg <= (tst_reg == TS_READ) ? addr_reg + 1'b1 : '0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN || tst_reg == TS_IDLE)
        begin
            crc_reg <= CRC_INIT;
            fail_reg <= 1'b0;
        end
        else if (vld_reg && vidx_reg != NVM_LAST)
        begin
            crc_reg <= crc8_step(crc_reg, nvm_bus.rd_data);
        end
        else if (vld_reg)
        begin
            fail_reg <= (nvm_bus.rd_data != crc_reg);
        end
    end

    assign CMD_READY = ready_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Query answers; the wait command needs nothing since execution is in order.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            RESP_VALID <= 1'b0;
            RESP_DATA <= RESP_RESET;
        end
        else
        begin
            RESP_VALID <= 1'b0;
            if (tst_reg == TS_DONE)
            begin
                RESP_VALID <= 1'b1;
                RESP_DATA <= fail_reg ? TST_FAIL : TST_PASS;
            end
            else if (taken)
            begin
                unique case (CMD_CODE)
                    CMD_ESE_Q: {RESP_VALID, RESP_DATA} <= {1'b1, ese_reg};
                    CMD_SRE_Q: {RESP_VALID, RESP_DATA} <= {1'b1, sre_reg};
                    CMD_ESR_Q: {RESP_VALID, RESP_DATA} <= {1'b1, esr_reg};
                    CMD_STB_Q: {RESP_VALID, RESP_DATA} <= {1'b1, stb};
                    default: RESP_VALID <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Status byte rebuilt from the sources without bit 6, and the reset command strobe.
    logic [7:0] stb_chk;
    logic mss_chk, rst_cmd_chk;
    assign stb_chk = {OPER_SUMMARY, 1'b0, esb, MSG_AVAILABLE, QUES_SUMMARY,
        ERROR_QUEUE_NONEMPTY, LIST_RUNNING, 1'b0};
    assign mss_chk = |(stb_chk & sre_reg);
    assign rst_cmd_chk = taken && CMD_CODE == CMD_RST;

    sequence s_trg_fire;
        trg_req && armed_reg && src_bus_reg;
    endsequence

    sequence s_trg_loaded;
        OUT_VOLT == $past(TRIG_VOLT) && OUT_CURR == $past(TRIG_CURR);
    endsequence

    a_sre_bit6_masked: assert property (taken && CMD_CODE == CMD_SRE |=>
        sre_reg == ($past(CMD_ARG) & SRE_WRITABLE)) else $error("mask bit 6 stored");
    a_stb_query_mss: assert property (taken && CMD_CODE == CMD_STB_Q |=>
        RESP_VALID && RESP_DATA[STB_MSS] == $past(mss_chk)) else $error("bad summary");
    a_poll_clears_rqs: assert property (SERIAL_POLL && !(mss && !mss_prev_reg) |=>
        !rqs_reg && POLL_DATA[STB_MSS] == $past(rqs_reg)) else $error("poll left request");
    a_esr_read_clear: assert property (taken && CMD_CODE == CMD_ESR_Q && esr_set == 8'h00
        |=> esr_reg == 8'h00 && RESP_DATA == $past(esr_reg)) else $error("esr not cleared");
    a_trig_gated: assert property (trg_req && !(armed_reg && src_bus_reg) &&
        !(taken && CMD_CODE == CMD_RST) |=> $stable(OUT_VOLT)) else $error("unarmed trigger");
    a_trig_load: assert property (s_trg_fire |=> s_trg_loaded ##0
        WAIT_FOR_TRIGGER == $past(cont_reg)) else $error("trigger load wrong");
    a_cont_rearm: assert property (s_trg_fire ##0 cont_reg |=> WAIT_FOR_TRIGGER ##1
        (WAIT_FOR_TRIGGER || $past(rst_cmd_chk))) else $error("no rearm");
    a_listen_only: assert property (taken && CMD_CODE == CMD_TRG && !LISTEN_ADDRESSED &&
        !GROUP_TRIGGER |=> $stable(OUT_VOLT) && $stable(WAIT_FOR_TRIGGER)) else $error("unaddressed");
    a_tst_answer: assert property (taken && CMD_CODE == CMD_TST_Q |=>
        !RESP_VALID ##[1:TST_MAX] RESP_VALID && RESP_DATA[7:1] == 7'h00) else $error("tst answer");
    a_unknown_cme: assert property (taken && !known |=> esr_reg[ESR_CME])
        else $error("command error lost");
    a_rst_output: assert property (taken && CMD_CODE == CMD_RST |=>
        !OUT_ON && OUT_VOLT == VOLT_ZERO && OUT_CURR == CURR_MIN) else $error("reset levels");
endmodule

// file: sbr_host_model.sv
// Bus controller model that hands common commands to the status block.
// Assumes one clock, commands taken at an edge with valid and ready both high.
`timescale 1ns/1ps
module sbr_host_model
    import sbr_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Command hand-over.
    output logic cmd_valid,
    output sbr_pkg::sbr_cmd_t cmd_code,
    output logic [7:0] cmd_arg,
    input wire logic cmd_ready,
    // Answers.
    input wire logic resp_valid,
    input wire logic [7:0] resp_data
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 5'h00;
        cmd_arg = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offers one command, holds it until taken, then waits for an answer if asked.
    task automatic issue(input sbr_cmd_t c, input logic [7:0] a, input bit q,
        output logic [7:0] r, output bit ok);
        int n;
        ok = 1'b1;
        r = 8'h00;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_arg <= a;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 100);
        cmd_valid <= 1'b0;
        ok = (cmd_ready === 1'b1);
        n = 0;
        while (q && ok && resp_valid !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (q && resp_valid === 1'b1)
            r = resp_data;
        else if (q)
            ok = 1'b0;
    endtask
endmodule

// file: status_byte_service_request_bench.sv
// Self-checking bench of the status byte, service request and trigger block.
// Assumes the store is eight bytes deep so the self-test stays short.
`timescale 1ns/1ps
module status_byte_service_request_bench;
    import sbr_pkg::*;
    logic clk, rstn, listen, gtrig, spoll, oper, ques, mav, errq, list, busy, errv, nvwe;
    logic cv, crdy, rv, pv, srq, on, wait_for_trigger;
    logic [1:0] ecls;
    logic [2:0] nva;
    logic [4:0] cc;
    logic [7:0] ca, rd, pd, nvd, r, crc;
    logic [15:0] tv, tc, ov, oc;
    int err_total, samples_checked;
    bit ok;

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    sbr_host_model host (.clk(clk), .cmd_valid(cv), .cmd_code(cc), .cmd_arg(ca),
        .cmd_ready(crdy), .resp_valid(rv), .resp_data(rd));

    sbr_status_top #(.NVM_DEPTH(8), .NVM_AW(3)) dut (.CLK(clk), .RSTN(rstn),
        .CMD_VALID(cv), .CMD_CODE(cc), .CMD_ARG(ca), .CMD_READY(crdy),
        .LISTEN_ADDRESSED(listen), .GROUP_TRIGGER(gtrig), .RESP_VALID(rv),
        .RESP_DATA(rd), .SERIAL_POLL(spoll), .POLL_VALID(pv), .POLL_DATA(pd),
        .SERVICE_REQUEST(srq), .OPER_SUMMARY(oper), .QUES_SUMMARY(ques),
        .MSG_AVAILABLE(mav), .ERROR_QUEUE_NONEMPTY(errq), .LIST_RUNNING(list),
        .OPS_BUSY(busy), .ERR_VALID(errv), .ERR_CLASS(ecls), .TRIG_VOLT(tv),
        .TRIG_CURR(tc), .OUT_VOLT(ov), .OUT_CURR(oc), .OUT_ON(on),
        .WAIT_FOR_TRIGGER(wait_for_trigger), .NV_WR_EN(nvwe), .NV_WR_ADDR(nva), .NV_WR_DATA(nvd));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A hung hand-over counts as a mismatch and ends the run.
    task automatic cmd(input sbr_cmd_t c, input logic [7:0] a, input bit q);
        host.issue(c, a, q, r, ok);
        if (!ok)
        begin
            err_total++;
            $display("BAD handshake expected %h seen none", c);
            tally_and_finish();
        end
    endtask

    task automatic ask(input sbr_cmd_t c, input string nm, input logic [7:0] e);
        cmd(c, 8'h00, 1'b1);
        chk(nm, {8'h00, e}, {8'h00, r});
    endtask

    task automatic poll(input logic [7:0] e);
        @(posedge clk);
        spoll <= 1'b1;
        @(posedge clk);
        spoll <= 1'b0;
        @(posedge clk);
        chk("poll valid", 16'h0001, {15'h0, pv});
        chk("poll data", {8'h00, e}, {8'h00, pd});
        chk("request after poll", 16'h0000, {15'h0, srq});
    endtask

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int b = 0; b < 8; b++)
            x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
        return x;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rstn, listen, gtrig, spoll, oper, ques, mav, errq, list, busy, errv, nvwe} = '0;
        ecls = 2'h0;
        nva = 3'h0;
        nvd = 8'h00;
        tv = 16'h1234;
        tc = 16'h0abc;
        err_total = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        ask(CMD_ESR_Q, "esr power on", 8'h80);
        ask(CMD_ESR_Q, "esr reread", 8'h00);
        cmd(5'h1f, 8'h00, 1'b0);
        ask(CMD_ESR_Q, "esr unknown", 8'h20);
        cmd(CMD_ESE, 8'd60, 1'b0);
        ask(CMD_ESE_Q, "ese mask", 8'd60);
        cmd(CMD_SRE, 8'hff, 1'b0);
        ask(CMD_SRE_Q, "sre bit6", 8'hbf);
        cmd(CMD_SRE, 8'd40, 1'b0);
        ask(CMD_SRE_Q, "sre mask", 8'd40);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            errv <= 1'b1;
            ecls <= 2'(k);
            @(posedge clk);
            errv <= 1'b0;
            ask(CMD_ESR_Q, "esr class", 8'h20 >> k);
        end
        poll(8'h40);
        // Execution error lifts the event summary and through it the request.
        @(posedge clk);
        errv <= 1'b1;
        ecls <= ERR_CLASS_EXE;
        @(posedge clk);
        errv <= 1'b0;
        repeat (3) @(posedge clk);
        chk("request", 16'h0001, {15'h0, srq});
        ask(CMD_STB_Q, "stb summary", 8'h60);
        poll(8'h60);
        ask(CMD_STB_Q, "stb after poll", 8'h60);
        poll(8'h20);
        @(posedge clk);
        {oper, ques, mav, errq, list} <= 5'h1f;
        ask(CMD_STB_Q, "stb all", 8'hfe);
        ask(CMD_STB_Q, "stb again", 8'hfe);
        {oper, mav, errq, list} <= 4'h0;
        ask(CMD_ESR_Q, "esr exe", 8'h10);
        ask(CMD_STB_Q, "stb ques", 8'h48);
        ques <= 1'b0;
        ask(CMD_STB_Q, "stb empty", 8'h00);
        busy <= 1'b1;
        cmd(CMD_OPC, 8'h00, 1'b0);
        cmd(CMD_WAI, 8'h00, 1'b0);
        ask(CMD_ESR_Q, "esr busy", 8'h00);
        busy <= 1'b0;
        repeat (2) @(posedge clk);
        ask(CMD_ESR_Q, "esr done", 8'h01);
        cmd(CMD_TRIG_SRC, 8'h01, 1'b0);
        cmd(CMD_INIT_IMM, 8'h00, 1'b0);
        cmd(CMD_TRG, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        chk("volt unaddressed", 16'h0000, ov);
        chk("armed", 16'h0001, {15'h0, wait_for_trigger});
        listen <= 1'b1;
        cmd(CMD_TRG, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        chk("volt trig", 16'h1234, ov);
        chk("curr trig", 16'h0abc, oc);
        chk("wait cleared", 16'h0000, {15'h0, wait_for_trigger});
        tv <= 16'h5555;
        cmd(CMD_TRG, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        chk("volt disarmed", 16'h1234, ov);
        cmd(CMD_INIT_CONT, 8'h01, 1'b0);
        @(posedge clk);
        gtrig <= 1'b1;
        @(posedge clk);
        gtrig <= 1'b0;
        repeat (2) @(posedge clk);
        chk("volt group", 16'h5555, ov);
        chk("rearmed", 16'h0001, {15'h0, wait_for_trigger});
        cmd(CMD_INIT_IMM, 8'h00, 1'b0);
        ask(CMD_ESR_Q, "esr init ignored", 8'h10);
        cmd(CMD_ABORT, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        chk("abort continuous", 16'h0001, {15'h0, wait_for_trigger});
        cmd(5'h1f, 8'h00, 1'b0);
        cmd(CMD_CLS, 8'h00, 1'b0);
        ask(CMD_ESR_Q, "esr cls", 8'h00);
        cmd(CMD_OUTP, 8'h01, 1'b0);
        repeat (2) @(posedge clk);
        chk("output on", 16'h0001, {15'h0, on});
        cmd(CMD_RST, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        chk("reset on", 16'h0000, {15'h0, on});
        chk("reset volt", 16'h0000, ov);
        chk("reset curr", 16'h0001, oc);
        crc = CRC_INIT;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            nvwe <= 1'b1;
            nva <= 3'(i);
            nvd <= (i < 7) ? 8'(i * 37 + 5) : crc;
            if (i < 7)
                crc = crc_step(crc, 8'(i * 37 + 5));
        end
        @(posedge clk);
        nva <= 3'h3;
        nvd <= 8'h00;
        nvwe <= 1'b0;
        ask(CMD_TST_Q, "self test good", TST_PASS);
        @(posedge clk);
        nvwe <= 1'b1;
        @(posedge clk);
        nvwe <= 1'b0;
        ask(CMD_TST_Q, "self test bad", TST_FAIL);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        ask(CMD_ESR_Q, "esr after reset", 8'h80);
        ask(CMD_SRE_Q, "sre after reset", SRE_RESET);
        tally_and_finish();
    end
endmodule
